// file: ddrsp_ctl_model.sv
`default_nettype none

module ddrsp_ctl_model
  import ddrsp_pkg::*;
(
  input  wire logic        clk_in,   // Bench clock
  output logic             k_t_out,  // True clock
  output logic             k_c_out,  // Comp clock
  output logic             ld_n_out = 1'b1, // Load strobe
  output logic             rw_out = 1'b1,   // High reads
  output logic [ADDR_W-1:0] a_out = '0,     // Address
  output logic [LANES-1:0]  be_n_out = 4'hF, // Byte enables
  output logic [DATA_W-1:0] d_out = '0      // Write data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph = 2'h0;

  // Quarter phases of an 80 ns clock, far below the unlocked limit
  initial begin
    #3;
    forever #20 ph = ph + 2'h1;
  end
  assign k_t_out = ~ph[1];
  assign k_c_out = ph[1];

  // Pins change mid-way between edges, clear of setup and hold
  task automatic wait_ph(input logic [1:0] n);
    logic [1:0] last;
    do begin
      last = ph;
      @(posedge clk_in);
    end while (!(ph == n && last != n));
  endtask

  // One cycle; its length keeps commands two K rises apart after a read or idle cycle, four after a write
  task automatic cycle(input logic ld_n, rd, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] base, input logic [LANES-1:0] be_n);
    wait_ph(2'h3);
    ld_n_out <= ld_n;
    rw_out   <= rd;
    a_out    <= a;
    wait_ph(2'h1);
    ld_n_out <= 1'b1;
    rw_out   <= ~rd;
    a_out    <= ~a;
    for (int i = 0; i < ((!ld_n && !rd) ? 5 : 2); i++) begin
      wait_ph(i[0] ? 2'h1 : 2'h3);
      if (!ld_n && !rd) begin
        d_out    <= (i == 4) ? ~d_out : base + DATA_W'(i);
        be_n_out <= (i == 4) ? 4'hF : be_n;
      end
    end
  endtask
endmodule

`default_nettype wire

// file: ddrsp_pin_sync.sv
`default_nettype none

module ddrsp_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,    // System clock
  input  wire logic         srst_in,   // Synchronous reset, high
  input  wire logic [W-1:0] pin_in,    // Raw pins from the link
  output logic      [W-1:0] level_out  // Filtered level per pin
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } ddrsp_sync_st_t;

  ddrsp_sync_st_t st_reg;
  ddrsp_sync_st_t st_next;

  // A bit only moves once stages two and three agree, which rejects
  // a single metastable sample; stage one feeds stage two only
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.lvl = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s2) |
                  ((st_reg.s2 ^ st_reg.s3) & st_reg.lvl);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;

endmodule

`default_nettype wire

// file: ddrsp_pkg.sv
`default_nettype none

package ddrsp_pkg;

  // Bus and array geometry (x36 wide build, x18 uses the low half)
  localparam int DATA_W     = 36;
  localparam int HALF_W     = 18;
  localparam int LANE_W     = 9;
  localparam int LANES      = 4;
  localparam int ADDR_W     = 18;
  localparam int ROW_W      = 19;
  localparam int MEM_ROWS   = 524288;
  localparam int BURST_LEN  = 4;

  // Output enable patterns (low drives the line) and the data word of a released bus
  localparam logic [DATA_W-1:0] OE_ALL_N   = 36'hFFFFFFFFF;
  localparam logic [DATA_W-1:0] OE_X36_N   = 36'h000000000;
  localparam logic [DATA_W-1:0] OE_X18_N   = 36'hFFFFC0000;
  localparam logic [DATA_W-1:0] DQ_RESET   = 36'h000000000;

  // Schedule in half-cycle ticks counted from the command's rising edge
  localparam int PIPE_DEPTH   = 9;
  localparam int WR_FIRST     = 2;
  localparam int RD_FIRST_DLL = 5;
  localparam int RD_FIRST_BYP = 2;

  // Loop lock time counted in rising edges of the true input clock
  localparam int LOCK_CNT_W   = 16;
  localparam int LOCK_KCYC    = 1024;

  // Pin synchroniser layout: one vector carries every input pin
  localparam int SYNC_W       = 63;
  localparam int POS_K_TRUE   = 0;
  localparam int POS_K_COMP   = 1;
  localparam int POS_LOAD_N   = 2;
  localparam int POS_RD_WR    = 3;
  localparam int POS_DLL_ON   = 4;
  localparam int POS_ADDR     = 5;
  localparam int POS_BE_N     = 23;
  localparam int POS_DATA     = 27;

  // One queued bus cycle
  typedef struct packed {
    logic              vld;
    logic              rd;
    logic [ADDR_W-1:0] addr;
  } ddrsp_cmd_t;

endpackage

`default_nettype wire

// file: ddrsp_sram_port.sv
`default_nettype none

// Notes on behaviour
// - Address and control taken on true-clock rise
// - Write data taken on both clock rises
// - Echo strobes switch with read data
// - Echo strobes run freely, even when idle
// - Loop off: bypass and clear lock state
// - Loop on: lock after set count
// - Loop off gives single-cycle read latency
// - Valid flag marks read words, echo aligned
// - Address ignored unless load strobe low
// - Bus driven only during active read beats
// - Narrow build uses low 18 lines only
// - Select high reads, low writes
// - Fixed four-word bursts; idle cycles never truncate
// - Locked read: first word 2.5 cycles later
// - Byte enables low, sampled with their word
module ddrsp_sram_port
  import ddrsp_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_KCYC
) (
  input  wire logic                clk_in,                 // System clock, 100 MHz
  input  wire logic                srst_in,                // Synchronous reset, high
  input  wire logic                cfg_x36_in,             // Width strap, high for 36 lines
  input  wire logic                k_true_in,              // True input clock
  input  wire logic                k_comp_in,              // Complementary input clock
  input  wire logic                load_cycle_n_in,        // Load strobe, low starts a cycle
  input  wire logic                rd_not_wr_in,           // High read, low write
  input  wire logic                dll_on_in,              // Low bypasses the delay loop
  input  wire logic [ADDR_W-1:0]   sync_address_in,        // Burst address
  input  wire logic [LANES-1:0]    byte_lane_enable_n_in,  // Byte enables, low writes
  input  wire logic [DATA_W-1:0]   shared_data_bus_in,     // Data bus as seen on the pins
  output logic      [DATA_W-1:0]   shared_data_bus_out,    // Read data driven out
  output logic      [DATA_W-1:0]   shared_data_bus_oe_n_out, // Low while driving a line
  output logic                     echo_strobe_true_out,   // Echo clock, true
  output logic                     echo_strobe_comp_out,   // Echo clock, complementary
  output logic                     read_valid_flag_out,    // High during read words
  output logic                     dll_locked_out          // High once the loop has locked
);

  // Lock point as a counter value; the counter stops one below it
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES);

  // Whole state of the port apart from the array in one record, registered in one place
  typedef struct packed {
    ddrsp_cmd_t [PIPE_DEPTH-1:0] pipe;
    logic                        k_prev;
    logic                        kc_prev;
    logic                        echo;
    logic [DATA_W-1:0]           dq;
    logic [DATA_W-1:0]           oe_n;
    logic                        valid;
    logic [LOCK_CNT_W-1:0]       lock_cnt;
    logic                        locked;
    logic                        x36;
  } ddrsp_state_t;

  ddrsp_state_t st_reg;
  ddrsp_state_t st_next;

  // Array storage; never reset, so unwritten rows read back unknown,
  // as they would on a real array after power-up
  logic [DATA_W-1:0] mem [0:MEM_ROWS-1];

  // Pins before and after the synchroniser
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins;

  // Clock edges and the cycle being loaded
  logic              k_lvl;
  logic              kc_lvl;
  logic              k_rise;
  logic              kc_rise;
  logic              tick;
  ddrsp_cmd_t        new_cmd;

  // Queue after this tick's shift
  ddrsp_cmd_t [PIPE_DEPTH-1:0] pipe_sh;

  // Owners of the read and write beats of this tick
  ddrsp_cmd_t        rd_slot;
  ddrsp_cmd_t        wr_slot;
  logic [1:0]        rd_beat;
  logic [1:0]        wr_beat;
  logic              rd_act;
  logic              wr_act;

  // Read word path
  logic [ROW_W-1:0]  rd_row;
  logic              rd_half;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rd_data;

  // Write word path, with lanes and data taken from the pins
  logic [ROW_W-1:0]  wr_row;
  logic [DATA_W-1:0] wr_data;
  logic [LANES-1:0]  wr_mask;
  logic [LANES-1:0]  be_n;
  logic [DATA_W-1:0] din;

  // Every pin crosses in one synchroniser so that clocks, strobes and
  // data keep the same delay and stay aligned to each other
  assign pins_raw = {shared_data_bus_in, byte_lane_enable_n_in, sync_address_in,
                     dll_on_in, rd_not_wr_in, load_cycle_n_in, k_comp_in, k_true_in};

  ddrsp_pin_sync #(
    .W (SYNC_W)
  ) u_pin_sync (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .pin_in    (pins_raw),
    .level_out (pins)
  );

  // Synchronised pins picked out of the vector
  assign k_lvl  = pins[POS_K_TRUE];
  assign kc_lvl = pins[POS_K_COMP];
  assign be_n   = pins[POS_BE_N +: LANES];
  assign din    = pins[POS_DATA +: DATA_W];

  // Only rising edges matter; the true clock wins if both land together
  // A lost K# rise needs the pair skewed by most of a half period
  assign k_rise  = k_lvl & ~st_reg.k_prev;
  assign kc_rise = kc_lvl & ~st_reg.kc_prev & ~k_rise;
  assign tick    = k_rise | kc_rise;

  // A new bus cycle is opened only on a true-clock rise with load low
  // Address is zeroed outside a load so stray address pins never enter the queue
  always_comb begin
    new_cmd      = '0;
    new_cmd.vld  = k_rise & ~pins[POS_LOAD_N];
    new_cmd.rd   = pins[POS_RD_WR];
    new_cmd.addr = new_cmd.vld ? pins[POS_ADDR +: ADDR_W] : '0;
  end

  // Shift the queue once per tick. Kept out of the next-state process
  // so that the beat finder does not loop back through it.
  always_comb begin
    if (tick) begin
      pipe_sh = {st_reg.pipe[PIPE_DEPTH-2:0], new_cmd};
    end else begin
      pipe_sh = st_reg.pipe;
    end
  end

  // Find which queued command owns the read and write beats of this tick.
  // The queue is looked at after the shift, so slot k is k ticks old.
  always_comb begin
    rd_slot = '0;
    wr_slot = '0;
    rd_beat = 2'h0;
    wr_beat = 2'h0;
    rd_act  = 1'b0;
    wr_act  = 1'b0;
    for (int b = 0; b < BURST_LEN; b++) begin
      if (st_reg.locked) begin
        if (pipe_sh[RD_FIRST_DLL + b].vld && pipe_sh[RD_FIRST_DLL + b].rd) begin
          rd_slot = pipe_sh[RD_FIRST_DLL + b];
          rd_beat = 2'(b);
          rd_act  = tick;
        end
      end else begin
        if (pipe_sh[RD_FIRST_BYP + b].vld && pipe_sh[RD_FIRST_BYP + b].rd) begin
          rd_slot = pipe_sh[RD_FIRST_BYP + b];
          rd_beat = 2'(b);
          rd_act  = tick;
        end
      end
      if (pipe_sh[WR_FIRST + b].vld && !pipe_sh[WR_FIRST + b].rd) begin
        wr_slot = pipe_sh[WR_FIRST + b];
        wr_beat = 2'(b);
        wr_act  = tick;
      end
    end
  end

  // Array row and half for a read word; the narrow build packs two
  // 18-bit words per row so both builds share one array
  always_comb begin
    if (st_reg.x36) begin
      rd_row  = {rd_slot.addr[ROW_W-3:0], rd_beat};
      rd_half = 1'b0;
    end else begin
      rd_row  = {rd_slot.addr, rd_beat[1]};
      rd_half = rd_beat[0];
    end
    rd_word = mem[rd_row];
    if (st_reg.x36) begin
      rd_data = rd_word;
    end else if (rd_half) begin
      rd_data = {{HALF_W{1'b0}}, rd_word[DATA_W-1:HALF_W]};
    end else begin
      rd_data = {{HALF_W{1'b0}}, rd_word[HALF_W-1:0]};
    end
  end

  // Write word placement and lane mask; lanes are sampled with the word
  // The narrow build copies its word into both halves; the mask picks one
  always_comb begin
    if (st_reg.x36) begin
      wr_row  = {wr_slot.addr[ROW_W-3:0], wr_beat};
      wr_data = din;
      wr_mask = ~be_n;
    end else begin
      wr_row  = {wr_slot.addr, wr_beat[1]};
      wr_data = {din[HALF_W-1:0], din[HALF_W-1:0]};
      if (wr_beat[0]) begin
        wr_mask = {~be_n[1:0], 2'b00};
      end else begin
        wr_mask = {2'b00, ~be_n[1:0]};
      end
    end
  end

  // Array write; kept apart from the state struct because it is storage
  // Lane by lane, so a disabled lane keeps what it held
  always_ff @(posedge clk_in) begin
    if (wr_act) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr_mask[l]) begin
          mem[wr_row][l*LANE_W +: LANE_W] <= wr_data[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Next state: queue, output words, echo strobes and loop lock
  always_comb begin
    st_next         = st_reg;
    st_next.k_prev  = k_lvl;
    st_next.kc_prev = kc_lvl;

    // The queue advances on every clock tick whether or not a cycle is
    // loaded, so an idle cycle cannot cut a burst short
    st_next.pipe = pipe_sh;

    // Echo strobes follow the input clocks on every tick, all the time
    // They keep running while the bus is released
    if (k_rise) begin
      st_next.echo = 1'b1;
    end else if (kc_rise) begin
      st_next.echo = 1'b0;
    end

    // Output words change on the same tick as the echo strobes; the bus
    // is released on the first tick without a read word
    if (tick) begin
      if (rd_act) begin
        st_next.dq    = rd_data;
        st_next.oe_n  = st_reg.x36 ? OE_X36_N : OE_X18_N;
        st_next.valid = 1'b1;
      end else begin
        st_next.dq    = DQ_RESET;
        st_next.oe_n  = OE_ALL_N;
        st_next.valid = 1'b0;
      end
    end

    // Loop lock: held clear while bypassed, counted in true-clock rises
    // once enabled. Latency switches at lock, so a controller must not
    // have reads in flight across that moment.
    if (!pins[POS_DLL_ON]) begin
      st_next.lock_cnt = '0;
      st_next.locked   = 1'b0;
    end else if (k_rise && !st_reg.locked) begin
      if (st_reg.lock_cnt >= LOCK_LAST - 1'b1) begin
        st_next.locked = 1'b1;
      end else begin
        st_next.lock_cnt = st_reg.lock_cnt + 1'b1;
      end
    end
  end

  // State register; the width strap is caught while reset is held
  // The strap is not read again, so a width change needs a reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg      <= '0;
      st_reg.oe_n <= OE_ALL_N;
      st_reg.x36  <= cfg_x36_in;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  // The complementary echo comes from the same flop, so the pair cannot skew
  assign shared_data_bus_out      = st_reg.dq;
  assign shared_data_bus_oe_n_out = st_reg.oe_n;
  assign echo_strobe_true_out     = st_reg.echo;
  assign echo_strobe_comp_out     = ~st_reg.echo;
  assign read_valid_flag_out      = st_reg.valid;
  assign dll_locked_out           = st_reg.locked;

endmodule

`default_nettype wire

// file: ddrsp_sram_port_asserts.sv
`default_nettype none

module ddrsp_sram_port_chk
  import ddrsp_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_KCYC,
  parameter int K_CLKS      = 8
) (
  input wire logic              clk_in,                   // System clock
  input wire logic              srst_in,                  // Reset
  input wire logic              cfg_x36_in,               // Width strap
  input wire logic              dll_on_in,                // Loop enable
  input wire logic [DATA_W-1:0] shared_data_bus_out,      // Read data
  input wire logic [DATA_W-1:0] shared_data_bus_oe_n_out, // Enables
  input wire logic              echo_strobe_true_out,     // Echo true
  input wire logic              echo_strobe_comp_out,     // Echo comp
  input wire logic              read_valid_flag_out,      // Valid flag
  input wire logic              dll_locked_out            // Locked
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK_MIN = (LOCK_CYCLES - 1) * K_CLKS;
  logic        echo_q_reg;
  logic [3:0]  vcnt_reg;
  logic [3:0]  still_reg;
  logic [1:0]  runs_reg;
  logic [15:0] on_reg;
  wire         echo_chg = echo_strobe_true_out != echo_q_reg;

  // Words per valid span, echo idle time, loop-on time
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      echo_q_reg <= 1'b0;
      vcnt_reg   <= 4'h0;
      still_reg  <= 4'h0;
      runs_reg   <= 2'h0;
      on_reg     <= 16'h0;
    end else begin
      echo_q_reg <= echo_strobe_true_out;
      vcnt_reg   <= read_valid_flag_out ? vcnt_reg + 4'(echo_chg) : 4'h0;
      still_reg  <= echo_chg ? 4'h0 : still_reg + 4'(still_reg != 4'hF);
      runs_reg   <= runs_reg + 2'(echo_chg && runs_reg != 2'h2);
      on_reg     <= dll_on_in ? on_reg + 16'(on_reg != 16'hFFFF) : 16'h0;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_echo_pair: assert property (echo_strobe_comp_out == !echo_strobe_true_out)
    else $error("echo pair not complementary");
  chk_echo_free_run: assert property (runs_reg == 2'h2 |-> still_reg < 4'h7)
    else $error("echo strobe stopped");
  chk_valid_on_echo: assert property ($changed(read_valid_flag_out) |-> $changed(echo_strobe_true_out))
    else $error("valid moved off an echo edge");
  chk_data_on_echo: assert property ($changed(shared_data_bus_out) |-> $changed(echo_strobe_true_out))
    else $error("read data moved off an echo edge");
  chk_drive_in_read: assert property (read_valid_flag_out |->
    shared_data_bus_oe_n_out == (cfg_x36_in ? OE_X36_N : OE_X18_N))
    else $error("bus not driven during read word");
  chk_idle_release: assert property (!read_valid_flag_out |->
    shared_data_bus_oe_n_out == OE_ALL_N && shared_data_bus_out == DQ_RESET)
    else $error("bus driven outside read");
  chk_burst_four: assert property ($fell(read_valid_flag_out) |-> vcnt_reg == 4'h4)
    else $error("read burst not four words");
  chk_lock_clear: assert property (!dll_on_in [*6] |=> !dll_locked_out)
    else $error("lock kept with loop off");
  chk_lock_time: assert property ($rose(dll_locked_out) |-> on_reg >= 16'(LOCK_MIN))
    else $error("lock came too early");

  cover property ($rose(read_valid_flag_out));
  cover property ($rose(dll_locked_out));
  cover property ($fell(dll_locked_out));
  cover property (read_valid_flag_out && !cfg_x36_in);
endmodule

bind ddrsp_sram_port ddrsp_sram_port_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .cfg_x36_in(cfg_x36_in), .dll_on_in(dll_on_in),
  .shared_data_bus_out(shared_data_bus_out), .shared_data_bus_oe_n_out(shared_data_bus_oe_n_out),
  .echo_strobe_true_out(echo_strobe_true_out), .echo_strobe_comp_out(echo_strobe_comp_out),
  .read_valid_flag_out(read_valid_flag_out), .dll_locked_out(dll_locked_out));

`default_nettype wire

// file: tb_top.sv
`default_nettype none

module tb_top
  import ddrsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [DATA_W-1:0] B1 = 36'h123456789;
  localparam logic [DATA_W-1:0] B2 = 36'hABCDEF012;
  logic              clk_in = 1'b0;
  logic              srst_in = 1'b1;
  logic              dll_on = 1'b0;
  logic              x36    = 1'b1;
  logic              k_t, k_c, ld_n, rw, e_t, e_c, vld, lck;
  logic              echo_q = 1'b0;
  logic              armed = 1'b0;
  logic [ADDR_W-1:0] adr;
  logic [LANES-1:0]  be_n;
  logic [DATA_W-1:0] drv, bus_in, dq, oe_n;
  logic [DATA_W-1:0] words[$];
  int                errors = 0;
  int                n_tests = 0;
  int                tick = 0;
  int                first_tick = -1;

  // Pin level: device where it drives, controller elsewhere
  assign bus_in = (dq & ~oe_n) | (drv & oe_n);

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  ddrsp_ctl_model u_ctl (.clk_in(clk_in), .k_t_out(k_t), .k_c_out(k_c), .ld_n_out(ld_n), .rw_out(rw),
    .a_out(adr), .be_n_out(be_n), .d_out(drv));

  ddrsp_sram_port #(.LOCK_CYCLES(8)) uut (.clk_in(clk_in), .srst_in(srst_in), .cfg_x36_in(x36),
    .k_true_in(k_t), .k_comp_in(k_c), .load_cycle_n_in(ld_n), .rd_not_wr_in(rw), .dll_on_in(dll_on),
    .sync_address_in(adr), .byte_lane_enable_n_in(be_n), .shared_data_bus_in(bus_in),
    .shared_data_bus_out(dq), .shared_data_bus_oe_n_out(oe_n), .echo_strobe_true_out(e_t),
    .echo_strobe_comp_out(e_c), .read_valid_flag_out(vld), .dll_locked_out(lck));

  // Echo ticks counted from the command's K rise; words caught per tick
  always @(negedge clk_in) begin
    if (e_t !== echo_q) begin
      tick = (armed && e_t) ? 0 : tick + 1;
      if (armed && e_t) armed = 1'b0;
      if (vld === 1'b1 && first_tick < 0) first_tick = tick;
      if (vld === 1'b1) words.push_back(dq);
    end
    if (ld_n === 1'b0) armed = 1'b1;
    echo_q = e_t;
  end

  task automatic chk(input logic [DATA_W-1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] en_n);
    for (int l = 0; l < LANES; l++) lane_mask[l*LANE_W +: LANE_W] = {LANE_W{~en_n[l]}};
  endfunction

  // Read with a write-looking idle cycle behind it, which must change nothing
  task automatic rd_check(input logic [DATA_W-1:0] ob, nb, input logic [LANES-1:0] en_n, input int lat);
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] w;
    m = lane_mask(en_n);
    w = x36 ? 36'hFFFFFFFFF : 36'h00003FFFF;
    words.delete();
    first_tick = -1;
    u_ctl.cycle(1'b0, 1'b1, 18'h10, '0, 4'hF);
    u_ctl.cycle(1'b1, 1'b0, 18'h10, '0, 4'h0);
    for (int i = 0; i < 200 && words.size() < 4; i++) @(posedge clk_in);
    repeat (20) @(posedge clk_in);
    chk(36'(words.size()), 36'h4);
    chk(36'(first_tick), 36'(lat));
    for (int i = 0; i < words.size() && i < 4; i++)
      chk(words[i], (((nb + 36'(i)) & m) | ((ob + 36'(i)) & ~m)) & w);
  endtask

  task automatic t_bypass();
    @(negedge clk_in);
    chk(oe_n, OE_ALL_N);
    chk(36'(lck), 36'h0);
    u_ctl.cycle(1'b0, 1'b0, 18'h10, B1, 4'h0);
    rd_check(B1, B1, 4'h0, 2);
    $display("t_bypass done");
  endtask

  task automatic t_lock();
    dll_on <= 1'b1;
    for (int i = 0; i < 300 && lck !== 1'b1; i++) @(posedge clk_in);
    chk(36'(lck), 36'h1);
    rd_check(B1, B1, 4'h0, 5);
    $display("t_lock done");
  endtask

  task automatic t_lanes();
    u_ctl.cycle(1'b0, 1'b0, 18'h10, B2, 4'h5);
    rd_check(B1, B2, 4'h5, 5);
    $display("t_lanes done");
  endtask

  task automatic t_unlock();
    dll_on <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(36'(lck), 36'h0);
    rd_check(B1, B2, 4'h5, 2);
    $display("t_unlock done");
  endtask

  // Mid-run reset into the narrow build: low 18 lines, lanes 0 and 1 only
  task automatic t_narrow();
    srst_in <= 1'b1;
    x36     <= 1'b0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    chk(oe_n, OE_ALL_N);
    chk(36'(vld), 36'h0);
    u_ctl.cycle(1'b0, 1'b0, 18'h10, B1, 4'h0);
    rd_check(B1, B1, 4'h0, 2);
    u_ctl.cycle(1'b0, 1'b0, 18'h10, B2, 4'hD);
    rd_check(B1, B2, 4'hD, 2);
    $display("t_narrow done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is a few microseconds; this cuts a hang short
  initial begin
    #60000;
    errors++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    t_bypass();
    t_lock();
    t_lanes();
    t_unlock();
    t_narrow();
    tally_and_finish();
  end
endmodule

`default_nettype wire
